// file: core/liu_cfg_pkg.sv
// Constants for the line interface global configuration registers.
// Assumes a byte-wide host port sampled on clk_i at 125 MHz.
package liu_cfg_pkg;

	localparam int NUM_CHANNELS = 8;
	localparam int SEG_WIDTH    = 7;
	localparam int DATA_WIDTH   = 8;
	localparam int ADDR_WIDTH   = 8;

	// Register offsets; segment offsets are channel * 0x10 plus the low nibble.
	localparam logic [3:0] SEG_SEVEN_LOW       = 4'he;
	localparam logic [3:0] SEG_EIGHT_LOW       = 4'hf;
	localparam logic [7:0] GLOBAL_CONTROL_ADDR = 8'h80;
	localparam logic [7:0] CLOCK_SELECT_ADDR   = 8'h81;

	// Global control field positions, and the segment sign bit.
	localparam int RAIL_FORMAT_BIT = 7;
	localparam int AUTO_ONES_BIT   = 6;
	localparam int RX_EDGE_BIT     = 5;
	localparam int TX_EDGE_BIT     = 4;
	localparam int POLARITY_BIT    = 3;
	localparam int IRQ_ENABLE_BIT  = 1;
	localparam int SOFT_RESET_POS  = 0;
	localparam int SEG_SIGN_BIT    = 6;

	// Clock select fields: synthesizer select in bits 6:3, upper part 7:3.
	localparam int SYNTH_SEL_HI = 6;
	localparam int SYNTH_SEL_LO = 3;
	localparam logic [7:0] SYNTH_SEL_MASK  = 8'h78;
	localparam logic [7:0] CLOCK_UPPER_MASK = 8'hf8;
	localparam logic [7:0] CLOCK_LOWER_MASK = 8'h07;

	// Writable bits and reset values.
	localparam logic [7:0] GLOBAL_CONTROL_MASK  = 8'hfb;
	localparam logic [7:0] GLOBAL_CONTROL_RESET = 8'h00;
	localparam logic [7:0] CLOCK_SELECT_RESET   = 8'h00;
	localparam logic [6:0] SEG_RESET            = 7'h00;

	// Soft reset hold time, rounded up to whole cycles.
	localparam int CLK_PERIOD_NS      = 8;
	localparam int SOFT_RESET_HOLD_US = 10;
	localparam int SOFT_RESET_HOLD_CYCLES = (SOFT_RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CNT_WIDTH = 11;

	typedef enum logic [1:0] {
		RESET_IDLE   = 2'b00,
		RESET_ARMING = 2'b01,
		RESET_ACTIVE = 2'b10
	} soft_reset_state_t;

endpackage

// file: core/channel_pulse_segments.sv
// Segment seven and eight storage for one channel.
// Assumes write strobes are already decoded for this channel.
`timescale 1ns/1ns
module channel_pulse_segments
	import liu_cfg_pkg::*;
(
	// Clock and reset.
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Decoded writes.
	input  wire logic                 wr_seven_i,
	input  wire logic                 wr_eight_i,
	input  wire logic [SEG_WIDTH-1:0] wdata_i,
	// Segment values and direction.
	output logic      [SEG_WIDTH-1:0] seg_seven_o,
	output logic      [SEG_WIDTH-1:0] seg_eight_o,
	output logic                      seven_positive_o,
	output logic                      eight_positive_o
);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			seg_seven_o <= SEG_RESET;
		end else if (wr_seven_i) begin
			seg_seven_o <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			seg_eight_o <= SEG_RESET;
		end else if (wr_eight_i) begin
			seg_eight_o <= wdata_i;
		end
	end

	// The top bit of each segment is its sign.
	assign seven_positive_o = seg_seven_o[SEG_SIGN_BIT];
	assign eight_positive_o = seg_eight_o[SEG_SIGN_BIT];

	seven_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_seven_i |=> seg_seven_o == $past(wdata_i))
		else $error("segment seven not stored");
	eight_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_eight_i |=> seg_eight_o == $past(wdata_i))
		else $error("segment eight not stored");
	seven_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!wr_seven_i |=> $stable(seg_seven_o))
		else $error("segment seven changed without write");
	sign_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_eight_i |=> eight_positive_o == $past(wdata_i[SEG_SIGN_BIT]))
		else $error("segment direction wrong");

endmodule

// file: core/soft_reset_timer.sv
// Qualifies the soft reset bit against its minimum hold time.
// Assumes the bit comes straight from the global control flop.
`timescale 1ns/1ns
module soft_reset_timer
	import liu_cfg_pkg::*;
(
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Soft reset request and the resulting internal reset.
	input  wire logic soft_bit_i,
	output logic      core_reset_o
);

	localparam logic [HOLD_CNT_WIDTH-1:0] HOLD_LAST = HOLD_CNT_WIDTH'(SOFT_RESET_HOLD_CYCLES);

	soft_reset_state_t           state_reg;
	logic [HOLD_CNT_WIDTH-1:0]   hold_cnt_reg;

	// A short glitch of the bit must not reset the core, so the bit is timed first.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= RESET_IDLE;
		end else begin
			unique case (state_reg)
				RESET_IDLE: begin
					if (soft_bit_i) state_reg <= RESET_ARMING;
				end
				RESET_ARMING: begin
					if (!soft_bit_i) state_reg <= RESET_IDLE;
					else if (hold_cnt_reg == HOLD_LAST) state_reg <= RESET_ACTIVE;
				end
				RESET_ACTIVE: begin
					if (!soft_bit_i) state_reg <= RESET_IDLE;
				end
				default: state_reg <= RESET_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_cnt_reg <= '0;
		end else if (state_reg == RESET_ARMING && soft_bit_i) begin
			hold_cnt_reg <= hold_cnt_reg + 1'b1;
		end else begin
			hold_cnt_reg <= '0;
		end
	end

	assign core_reset_o = (state_reg == RESET_ACTIVE);

	hold_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(core_reset_o) |-> $past(hold_cnt_reg) == HOLD_LAST)
		else $error("core reset entered before hold time");
	reset_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
		core_reset_o && !soft_bit_i |=> !core_reset_o)
		else $error("core reset outlived the soft reset bit");

endmodule

// file: core/liu_global_config_regs.sv
// Host registers for pulse segments seven and eight, global control and clock select.
// Assumes a synchronous byte-wide host port; reads answer one cycle after rd_i.
`timescale 1ns/1ns
module liu_global_config_regs
	import liu_cfg_pkg::*;
(
	// Clock and reset.
	input  wire logic                                clk_i,
	input  wire logic                                rst_i,
	// Host register port.
	input  wire logic [ADDR_WIDTH-1:0]               addr_i,
	input  wire logic                                wr_i,
	input  wire logic                                rd_i,
	input  wire logic [DATA_WIDTH-1:0]               wdata_i,
	output logic      [DATA_WIDTH-1:0]               rdata_o,
	output logic                                     rd_ack_o,
	// Channel status.
	input  wire logic [NUM_CHANNELS-1:0]             rx_signal_loss_i,
	input  wire logic [NUM_CHANNELS-1:0]             status_change_i,
	input  wire logic [NUM_CHANNELS-1:0]             chan_irq_enable_i,
	// Channel controls.
	output logic      [NUM_CHANNELS-1:0]             tx_all_ones_o,
	output logic                                     irq_o,
	output logic                                     core_reset_o,
	// Global line configuration.
	output logic                                     rail_format_select_o,
	output logic                                     rx_output_edge_select_o,
	output logic                                     tx_sample_edge_select_o,
	output logic                                     data_polarity_select_o,
	// Synthesizer control.
	output logic      [SYNTH_SEL_HI:SYNTH_SEL_LO+1]  synth_select_o,
	output logic                                     master_rate_select_o,
	output logic                                     synth_retune_o,
	// Pulse segments.
	output logic      [NUM_CHANNELS*SEG_WIDTH-1:0]   seg_seven_o,
	output logic      [NUM_CHANNELS*SEG_WIDTH-1:0]   seg_eight_o,
	output logic      [NUM_CHANNELS-1:0]             seven_positive_o,
	output logic      [NUM_CHANNELS-1:0]             eight_positive_o
);

	// Segment registers sit below 0x80 with the channel in bits 6:4.
	function automatic logic seg_hit(input logic [7:0] a, input logic [3:0] low, input logic [2:0] ch);
		seg_hit = !a[7] && (a[3:0] == low) && (a[6:4] == ch);
	endfunction

	logic [DATA_WIDTH-1:0] global_control_reg;
	logic [DATA_WIDTH-1:0] clock_select_reg;
	logic [DATA_WIDTH-1:0] rd_next;
	logic [SEG_WIDTH-1:0]  seven_q [NUM_CHANNELS];
	logic [SEG_WIDTH-1:0]  eight_q [NUM_CHANNELS];
	logic                  gc_write;
	logic                  cs_write;
	logic                  synth_change;

	assign gc_write     = wr_i && (addr_i == GLOBAL_CONTROL_ADDR);
	assign cs_write     = wr_i && (addr_i == CLOCK_SELECT_ADDR);
	assign synth_change = |((wdata_i ^ clock_select_reg) & SYNTH_SEL_MASK);

	// Host registers reset only on rst_i; the soft reset never reaches them.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			global_control_reg <= GLOBAL_CONTROL_RESET;
		end else if (gc_write) begin
			global_control_reg <= wdata_i & GLOBAL_CONTROL_MASK;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			clock_select_reg <= CLOCK_SELECT_RESET;
		end else if (cs_write) begin
			clock_select_reg <= wdata_i;
		end
	end

	// Retune only on a real change of select or rate; other bits leave the synthesizer alone.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			synth_retune_o <= 1'b0;
		end else begin
			synth_retune_o <= cs_write && synth_change;
		end
	end

	assign synth_select_o       = clock_select_reg[SYNTH_SEL_HI:SYNTH_SEL_LO+1];
	assign master_rate_select_o = clock_select_reg[SYNTH_SEL_LO];

	assign rail_format_select_o    = global_control_reg[RAIL_FORMAT_BIT];
	assign rx_output_edge_select_o = global_control_reg[RX_EDGE_BIT];
	assign tx_sample_edge_select_o = global_control_reg[TX_EDGE_BIT];
	assign data_polarity_select_o  = global_control_reg[POLARITY_BIT];

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
			channel_pulse_segments u_segs (
				.clk_i            (clk_i),
				.rst_i            (rst_i),
				.wr_seven_i       (wr_i && seg_hit(addr_i, SEG_SEVEN_LOW, 3'(ch))),
				.wr_eight_i       (wr_i && seg_hit(addr_i, SEG_EIGHT_LOW, 3'(ch))),
				.wdata_i          (wdata_i[SEG_WIDTH-1:0]),
				.seg_seven_o      (seven_q[ch]),
				.seg_eight_o      (eight_q[ch]),
				.seven_positive_o (seven_positive_o[ch]),
				.eight_positive_o (eight_positive_o[ch])
			);
			assign seg_seven_o[ch*SEG_WIDTH +: SEG_WIDTH] = seven_q[ch];
			assign seg_eight_o[ch*SEG_WIDTH +: SEG_WIDTH] = eight_q[ch];
		end
	endgenerate

	soft_reset_timer u_soft_reset (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.soft_bit_i   (global_control_reg[SOFT_RESET_POS]),
		.core_reset_o (core_reset_o)
	);

	// Channel logic is part of the core, so it drops to idle under the soft reset.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_all_ones_o <= '0;
		end else if (core_reset_o) begin
			tx_all_ones_o <= '0;
		end else begin
			tx_all_ones_o <= rx_signal_loss_i & {NUM_CHANNELS{global_control_reg[AUTO_ONES_BIT]}};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= !core_reset_o && global_control_reg[IRQ_ENABLE_BIT]
				&& |(status_change_i & chan_irq_enable_i);
		end
	end

	// Read data; bit 7 of segments and unmapped addresses read as zero.
	always_comb begin
		rd_next = '0;
		if (addr_i == GLOBAL_CONTROL_ADDR) begin
			rd_next = global_control_reg;
		end else if (addr_i == CLOCK_SELECT_ADDR) begin
			rd_next = clock_select_reg;
		end else if (seg_hit(addr_i, SEG_SEVEN_LOW, addr_i[6:4])) begin
			rd_next = {1'b0, seven_q[addr_i[6:4]]};
		end else if (seg_hit(addr_i, SEG_EIGHT_LOW, addr_i[6:4])) begin
			rd_next = {1'b0, eight_q[addr_i[6:4]]};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			rdata_o <= rd_next;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ack_o <= 1'b0;
		end else begin
			rd_ack_o <= rd_i;
		end
	end

	sequence gc_write_s;
		wr_i && addr_i == GLOBAL_CONTROL_ADDR;
	endsequence

	sequence gc_read_s;
		rd_i && !wr_i && addr_i == GLOBAL_CONTROL_ADDR;
	endsequence

	sequence cs_retune_write_s;
		cs_write && synth_change;
	endsequence

	rail_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
		gc_write_s |=> rail_format_select_o == $past(wdata_i[RAIL_FORMAT_BIT]))
		else $error("rail format select not taken");

	auto_ones_a: assert property (@(posedge clk_i) disable iff (rst_i)
		global_control_reg[AUTO_ONES_BIT] && !core_reset_o |=> tx_all_ones_o == $past(rx_signal_loss_i))
		else $error("all ones not sent on signal loss");

	ones_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!global_control_reg[AUTO_ONES_BIT] |=> tx_all_ones_o == '0)
		else $error("all ones sent while disabled");

	edge_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
		gc_write_s |=> tx_sample_edge_select_o == $past(wdata_i[TX_EDGE_BIT])
			&& rx_output_edge_select_o == $past(wdata_i[RX_EDGE_BIT]))
		else $error("clock edge selects not taken");

	irq_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!global_control_reg[IRQ_ENABLE_BIT] |=> !irq_o)
		else $error("interrupt without global enable");

	irq_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)
		global_control_reg[IRQ_ENABLE_BIT] && !core_reset_o && |(status_change_i & chan_irq_enable_i)
		|=> irq_o)
		else $error("enabled status change gave no interrupt");

	regs_kept_a: assert property (@(posedge clk_i) disable iff (rst_i)
		core_reset_o && !wr_i |=> $stable(global_control_reg) && $stable(clock_select_reg))
		else $error("host register changed under soft reset");

	retune_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cs_retune_write_s |=> synth_retune_o ##1 (!synth_retune_o || $past(cs_write && synth_change)))
		else $error("synthesizer retune pulse wrong");

	no_retune_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!cs_write |=> !synth_retune_o)
		else $error("retune without clock select write");

	reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		gc_read_s |=> rd_ack_o && rdata_o[2] == 1'b0 && rdata_o == $past(global_control_reg))
		else $error("global control read back wrong");

	polarity_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		gc_write_s |=> data_polarity_select_o == $past(wdata_i[POLARITY_BIT]))
		else $error("data polarity select not taken");

	reserved_kept_a: assert property (@(posedge clk_i) disable iff (rst_i)
		gc_write_s |=> (global_control_reg & ~GLOBAL_CONTROL_MASK) == '0)
		else $error("reserved global bit stored");

	global_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!gc_write |=> $stable(global_control_reg))
		else $error("global control changed without write");

	soft_link_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!global_control_reg[SOFT_RESET_POS] |=> !core_reset_o)
		else $error("core reset without soft reset bit");

	soft_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		core_reset_o && global_control_reg[SOFT_RESET_POS] |=> core_reset_o)
		else $error("core reset dropped while bit still set");

	ones_soft_a: assert property (@(posedge clk_i) disable iff (rst_i)
		core_reset_o |=> tx_all_ones_o == '0)
		else $error("all ones sent under core reset");

	irq_soft_a: assert property (@(posedge clk_i) disable iff (rst_i)
		core_reset_o |=> !irq_o)
		else $error("interrupt under core reset");

	irq_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(|(status_change_i & chan_irq_enable_i)) |=> !irq_o)
		else $error("interrupt without enabled status change");

	clock_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cs_write |=> clock_select_reg == $past(wdata_i))
		else $error("clock select not stored");

	synth_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cs_write |=> {synth_select_o, master_rate_select_o} == $past(wdata_i[SYNTH_SEL_HI:SYNTH_SEL_LO]))
		else $error("synthesizer select not taken");

	retune_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cs_write && !synth_change |=> !synth_retune_o)
		else $error("retune without select change");

	seven_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && seg_hit(addr_i, SEG_SEVEN_LOW, addr_i[6:4]) |=> rdata_o == {1'b0, $past(seven_q[addr_i[6:4]])})
		else $error("segment seven read back wrong");

	eight_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && seg_hit(addr_i, SEG_EIGHT_LOW, addr_i[6:4]) |=> rdata_o == {1'b0, $past(eight_q[addr_i[6:4]])})
		else $error("segment eight read back wrong");

	unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i && addr_i[7] && addr_i[6:1] != 6'h00 |=> rdata_o == '0)
		else $error("unmapped address read not zero");

	read_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_i |=> rd_ack_o)
		else $error("read not answered");

	read_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rd_i |=> !rd_ack_o && $stable(rdata_o))
		else $error("read answer without read");

endmodule

// file: verification/host_bus_model.sv
// Host processor model that drives the byte-wide register port.
// Assumes the design takes a strobe at a rising clk_i edge and answers a read one cycle later.
`timescale 1ns/1ns
module host_bus_model
	import liu_cfg_pkg::*;
(
	// Clock.
	input  wire logic                  clk_i,
	// Register port.
	output logic      [ADDR_WIDTH-1:0] addr_o,
	output logic                       wr_o,
	output logic                       rd_o,
	output logic      [DATA_WIDTH-1:0] wdata_o,
	input  wire logic [DATA_WIDTH-1:0] rdata_i,
	input  wire logic                  rd_ack_i
);
	initial begin
		addr_o  = 8'h00;
		wr_o    = 1'b0;
		rd_o    = 1'b0;
		wdata_o = 8'h00;
	end
	// Released lines show the inverse, so a stale value is never taken for a live one.
	task automatic release_bus();
		addr_o  <= ~addr_o;
		wdata_o <= ~wdata_o;
	endtask
	task automatic write_reg(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] d);
		@(posedge clk_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		release_bus();
	endtask
	task automatic read_reg(input logic [ADDR_WIDTH-1:0] a, output logic [DATA_WIDTH-1:0] q);
		int n;
		q = 8'hxx;
		@(posedge clk_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		release_bus();
		// The answer is looked at once the edge has settled, never in the edge's own time step.
		#1;
		for (n = 0; n < 4 && rd_ack_i !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		if (rd_ack_i === 1'b1) begin
			q = rdata_i;
		end
	endtask
	// Both halves changing at once could upset the synthesizer while it settles.
	task automatic clk_sel_write(input logic [DATA_WIDTH-1:0] old_v, input logic [DATA_WIDTH-1:0] new_v);
		logic [DATA_WIDTH-1:0] diff;
		diff = old_v ^ new_v;
		if ((diff & CLOCK_UPPER_MASK) != 8'h00 && (diff & CLOCK_LOWER_MASK) != 8'h00) begin
			write_reg(CLOCK_SELECT_ADDR, (new_v & CLOCK_UPPER_MASK) | (old_v & CLOCK_LOWER_MASK));
			write_reg(CLOCK_SELECT_ADDR, new_v);
		end else begin
			write_reg(CLOCK_SELECT_ADDR, new_v);
		end
	endtask
endmodule

// file: verification/liu_global_config_regs_tb_top.sv
// Self-checking bench for the global configuration registers.
// Assumes the host model owns the register port and the bench drives the channel status inputs.
`timescale 1ns/1ns
module liu_global_config_regs_tb_top;
	import liu_cfg_pkg::*;
	logic                              clk_i;
	logic                              rst_i;
	logic [ADDR_WIDTH-1:0]             addr;
	logic                              wr;
	logic                              rd;
	logic [DATA_WIDTH-1:0]             wdata;
	logic [DATA_WIDTH-1:0]             rdata;
	logic                              rd_ack;
	logic [NUM_CHANNELS-1:0]           loss;
	logic [NUM_CHANNELS-1:0]           status;
	logic [NUM_CHANNELS-1:0]           chan_en;
	logic [NUM_CHANNELS-1:0]           all_ones;
	logic                              irq;
	logic                              core_rst;
	logic                              rail;
	logic                              rx_edge;
	logic                              tx_edge;
	logic                              pol;
	logic [2:0]                        synth_sel;
	logic                              rate;
	logic                              retune;
	logic [NUM_CHANNELS*SEG_WIDTH-1:0] seven;
	logic [NUM_CHANNELS*SEG_WIDTH-1:0] eight;
	logic [NUM_CHANNELS-1:0]           seven_pos;
	logic [NUM_CHANNELS-1:0]           eight_pos;
	logic [7:0]                        q;
	int                                failures;
	int                                compares;
	int                                retunes = 0;
	int                                n;

	host_bus_model host (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
		.rdata_i(rdata), .rd_ack_i(rd_ack));
	liu_global_config_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
		.wdata_i(wdata), .rdata_o(rdata), .rd_ack_o(rd_ack), .rx_signal_loss_i(loss),
		.status_change_i(status), .chan_irq_enable_i(chan_en), .tx_all_ones_o(all_ones), .irq_o(irq),
		.core_reset_o(core_rst), .rail_format_select_o(rail), .rx_output_edge_select_o(rx_edge),
		.tx_sample_edge_select_o(tx_edge), .data_polarity_select_o(pol), .synth_select_o(synth_sel),
		.master_rate_select_o(rate), .synth_retune_o(retune), .seg_seven_o(seven), .seg_eight_o(eight),
		.seven_positive_o(seven_pos), .eight_positive_o(eight_pos));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (retune === 1'b1) begin
			retunes <= retunes + 1;
		end
	end

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: register read %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_port(input logic [55:0] got, input logic [55:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: port value %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_cyc(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask
	task automatic end_sim();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		end_sim();
	end

	initial begin
		failures = 0;
		compares = 0;
		rst_i    = 1'b1;
		loss     = 8'h00;
		status   = 8'h00;
		chan_en  = 8'h00;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		host.read_reg(GLOBAL_CONTROL_ADDR, q);
		chk_reg(q, 8'h00);
		host.read_reg(CLOCK_SELECT_ADDR, q);
		chk_reg(q, 8'h00);
		chk_port(56'({rail, rx_edge, tx_edge, pol, core_rst}), 56'h0);
		$display("test reset done");
		for (n = 0; n < NUM_CHANNELS; n++) begin
			host.write_reg(8'(n * 16 + 14), 8'hc0 | 8'(n));
			host.write_reg(8'(n * 16 + 15), 8'h80 | 8'(n * 4));
		end
		for (n = 0; n < NUM_CHANNELS; n++) begin
			host.read_reg(8'(n * 16 + 14), q);
			chk_reg(q, 8'h40 | 8'(n));
			host.read_reg(8'(n * 16 + 15), q);
			chk_reg(q, 8'(n * 4));
			chk_port(56'(seven[n*7+:7]), 56'(7'h40 | 7'(n)));
			chk_port(56'(eight[n*7+:7]), 56'(7'(n * 4)));
		end
		chk_port(56'({seven_pos, eight_pos}), 56'hff00);
		$display("test segments done");
		host.write_reg(GLOBAL_CONTROL_ADDR, 8'hae);
		wait_cyc(1);
		chk_port(56'({rail, rx_edge, tx_edge, pol}), 56'hd);
		host.read_reg(GLOBAL_CONTROL_ADDR, q);
		chk_reg(q, 8'haa);
		host.write_reg(GLOBAL_CONTROL_ADDR, 8'h04);
		wait_cyc(1);
		chk_port(56'({rail, rx_edge, tx_edge, pol}), 56'h0);
		host.read_reg(8'h90, q);
		chk_reg(q, 8'h00);
		$display("test global control done");
		loss    <= 8'h5a;
		status  <= 8'h30;
		chan_en <= 8'h10;
		wait_cyc(3);
		chk_port(56'({all_ones, irq}), 56'h0);
		host.write_reg(GLOBAL_CONTROL_ADDR, 8'h42);
		wait_cyc(2);
		chk_port(56'({all_ones, irq}), 56'hb5);
		chan_en <= 8'h01;
		wait_cyc(3);
		chk_port(56'(irq), 56'h0);
		chan_en <= 8'h10;
		$display("test auto ones and interrupt done");
		host.write_reg(GLOBAL_CONTROL_ADDR, 8'h43);
		wait_cyc(1000);
		host.write_reg(GLOBAL_CONTROL_ADDR, 8'h42);
		chk_port(56'(core_rst), 56'h0);
		// The host holds the bit for just under the minimum and checks that the core is not yet reset.
		host.write_reg(GLOBAL_CONTROL_ADDR, 8'h43);
		wait_cyc(1240);
		chk_port(56'(core_rst), 56'h0);
		for (n = 0; n < 20 && core_rst !== 1'b1; n++) begin
			wait_cyc(1);
		end
		// The channel outputs are registered, so they fall one cycle after the core reset rises.
		wait_cyc(1);
		chk_port(56'({core_rst, all_ones, irq}), 56'h200);
		host.read_reg(GLOBAL_CONTROL_ADDR, q);
		chk_reg(q, 8'h43);
		host.read_reg(8'h3e, q);
		chk_reg(q, 8'h43);
		host.write_reg(GLOBAL_CONTROL_ADDR, 8'h42);
		wait_cyc(3);
		chk_port(56'({core_rst, all_ones, irq}), 56'hb5);
		$display("test soft reset done");
		host.clk_sel_write(8'h00, 8'h78);
		host.read_reg(CLOCK_SELECT_ADDR, q);
		chk_reg(q, 8'h78);
		chk_port(56'({synth_sel, rate, 32'(retunes)}), 56'hf00000001);
		host.clk_sel_write(8'h78, 8'h05);
		host.read_reg(CLOCK_SELECT_ADDR, q);
		chk_reg(q, 8'h05);
		chk_port(56'({synth_sel, rate, 32'(retunes)}), 56'h000000002);
		host.clk_sel_write(8'h05, 8'h0d);
		host.read_reg(CLOCK_SELECT_ADDR, q);
		chk_reg(q, 8'h0d);
		chk_port(56'({synth_sel, rate, 32'(retunes)}), 56'h100000003);
		$display("test clock select done");
		end_sim();
	end
endmodule
